// ==== rtl/adccr_pkg.sv ====
// Constants shared by the converter computation register block
package adccr_pkg;
    // Register byte addresses, low byte first
    localparam logic [15:0] ADDR_LOWER_L = 16'h1D0C;
    localparam logic [15:0] ADDR_LOWER_H = 16'h1D0D;
    localparam logic [15:0] ADDR_UPPER_L = 16'h1D0E;
    localparam logic [15:0] ADDR_UPPER_H = 16'h1D0F;
    localparam logic [15:0] ADDR_DEV_L = 16'h1D10;
    localparam logic [15:0] ADDR_DEV_H = 16'h1D11;
    localparam logic [15:0] ADDR_SETPT_L = 16'h1D12;
    localparam logic [15:0] ADDR_SETPT_H = 16'h1D13;
    localparam logic [15:0] ADDR_FILT_L = 16'h1D14;
    localparam logic [15:0] ADDR_FILT_H = 16'h1D15;
    localparam logic [15:0] ADDR_SUM_L = 16'h1D16;
    localparam logic [15:0] ADDR_SUM_H = 16'h1D17;
    localparam logic [15:0] ADDR_SUM_U = 16'h1D18;
    localparam logic [15:0] ADDR_TALLY = 16'h1D19;
    localparam logic [15:0] ADDR_TARGET = 16'h1D1A;
    localparam logic [15:0] ADDR_PRIOR_L = 16'h1D1B;
    localparam logic [15:0] ADDR_PRIOR_H = 16'h1D1C;
    localparam logic [15:0] ADDR_SAMPLE_L = 16'h1D1D;
    localparam logic [15:0] ADDR_SAMPLE_H = 16'h1D1E;
    localparam logic [15:0] ADDR_CHARGE = 16'h1D23;
    // Field layout and reset values
    localparam int CHARGE_W = 5;
    localparam int SUM_W = 18;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [17:0] RST_SUM = 18'h00000;
    // Computation modes
    typedef enum logic [2:0] {
        ADCCR_MODE_BASIC = 3'h0,
        ADCCR_MODE_ACCUM = 3'h1,
        ADCCR_MODE_AVG = 3'h2,
        ADCCR_MODE_BURST = 3'h3,
        ADCCR_MODE_LPF = 3'h4
    } adccr_mode_t;
    // Deviation formulas
    localparam logic [2:0] ERROR_FORMULA_SELECT_SAMPLE_PRIOR = 3'h0;
    localparam logic [2:0] ERROR_FORMULA_SELECT_SAMPLE_SETPT = 3'h1;
    localparam logic [2:0] ERROR_FORMULA_SELECT_PRIOR_SETPT = 3'h2;
    localparam logic [2:0] ERROR_FORMULA_SELECT_FILT_SETPT = 3'h3;
    localparam logic [2:0] ERROR_FORMULA_SELECT_FILT_PRIOR = 3'h4;
    // Threshold interrupt modes
    localparam logic [2:0] TMD_NEVER = 3'h0;
    localparam logic [2:0] TMD_BELOW = 3'h1;
    localparam logic [2:0] TMD_NOT_BELOW = 3'h2;
    localparam logic [2:0] TMD_INSIDE = 3'h3;
    localparam logic [2:0] TMD_OUTSIDE = 3'h4;
    localparam logic [2:0] TMD_NOT_ABOVE = 3'h5;
    localparam logic [2:0] TMD_ABOVE = 3'h6;
    localparam logic [2:0] TMD_ALWAYS = 3'h7;
endpackage : adccr_pkg

// ==== rtl/adccr_regs.sv ====
// Converter computation registers: result, sum, filter, deviation and thresholds
// What this block does
// - Extra sampling capacitance output equals the 5-bit select, zero means none.
// - Threshold check happens when the trigger tally equals the repeat target.
// - Trigger tally counts each trigger before the check; software may read and write.
// - Tally and target only used in low-pass, burst average and average modes.
// - Accumulate, average and burst modes: filtered output is sum shifted right.
// - Low-pass mode: filtered output is the low-pass filter result.
// - Filtered output is 16-bit signed, read-only, as high and low bytes.
// - Sample outcome is a 16-bit read/write register in two bytes.
// - Prior select one: copy filtered output to earlier outcome at conversion start.
// - Prior select zero: copy sample outcome to earlier outcome at conversion start.
// - Prior select zero: earlier outcome keeps the sample outcome's format.
// - Running sum is 18-bit signed; upper unused bits read as sign copies.
// - Running sum writes accepted only while no conversion is active.
// - Running sum seen as three bytes; upper byte holds bits 17 and 16.
// - Setpoint is a 16-bit signed read/write value used by some formulas.
// - Setpoint deviation is 16-bit signed read-only, formula chosen by select.
// - Deviation compared with bounds sets below-lower and above-upper flags.
// - Threshold interrupt raised from comparison per interrupt mode field.
// - Lower and upper bounds are 16-bit signed read/write in two bytes.
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module adccr_regs
    import adccr_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int SHIFT_W = 3
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_conv_start,
    input wire logic i_conv_done,
    input wire logic [15:0] i_conv_data,
    input wire logic i_conv_active,
    input wire logic [2:0] i_comp_mode,
    input wire logic [SHIFT_W-1:0] i_shift_amount,
    input wire logic i_prior_source_select,
    input wire logic [2:0] i_error_formula_select,
    input wire logic [2:0] i_threshold_irq_mode,
    output logic [adccr_pkg::CHARGE_W-1:0] o_extra_charge_pf,
    output logic o_below_lower_flag,
    output logic o_above_upper_flag,
    output logic o_threshold_irq
);
    import adccr_pkg::*;

    logic [15:0] lower_ff, upper_ff, setpt_ff, dev_ff, filt_ff, prior_ff, sample_ff;
    logic [17:0] sum_ff, nxt_sum;
    logic [7:0] tally_ff, target_ff, nxt_tally, rdata_ff;
    logic [CHARGE_W-1:0] charge_ff;
    logic check_ff, below_ff, above_ff, irq_ff;
    logic repeat_mode, sum_mode, tally_hit, do_check, sw_sum_ok;
    logic [15:0] dev_error_formula_select;
    logic dev_below, dev_above, irq_error_formula_select;

    // Sign-extend a 16-bit word to sum width
    function automatic logic [17:0] sext18(input logic [15:0] v);
        sext18 = {{2{v[15]}}, v};
    endfunction : sext18

    // Software write hit on one byte address
    function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic [15:0] target);
        wr_hit = i_wr && (a == target[ADDR_W-1:0]);
    endfunction : wr_hit

    // Mode decode
    assign repeat_mode = (i_comp_mode == ADCCR_MODE_AVG) || (i_comp_mode == ADCCR_MODE_BURST)
        || (i_comp_mode == ADCCR_MODE_LPF);
    assign sum_mode = repeat_mode || (i_comp_mode == ADCCR_MODE_ACCUM);
    assign nxt_tally = tally_ff + 8'h01;
    assign tally_hit = (nxt_tally == target_ff);
    assign do_check = i_conv_done && (!repeat_mode || tally_hit);
    assign sw_sum_ok = !i_conv_active;

    // Sample outcome: conversion wins over a software write
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sample_ff <= RST_WORD;
        end else if (i_conv_done) begin
            sample_ff <= i_conv_data;
        end else if (wr_hit(i_addr, ADDR_SAMPLE_L)) begin
            sample_ff[7:0] <= i_wdata;
        end else if (wr_hit(i_addr, ADDR_SAMPLE_H)) begin
            sample_ff[15:8] <= i_wdata;
        end
    end

    // Earlier outcome snapshot at conversion start
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            prior_ff <= RST_WORD;
        end else if (i_conv_start) begin
            if (i_prior_source_select) begin
                prior_ff <= filt_ff;
            end else begin
                prior_ff <= sample_ff;
            end
        end
    end

    // Running sum next value
    always_comb begin
        nxt_sum = sum_ff;
        if (i_conv_done && sum_mode) begin
            if (i_comp_mode == ADCCR_MODE_LPF) begin
                nxt_sum = sum_ff + sext18(i_conv_data) - SUM_W'($signed(sum_ff) >>> i_shift_amount);
            end else if (i_comp_mode == ADCCR_MODE_AVG && tally_ff == 8'h00) begin
                nxt_sum = sext18(i_conv_data); // Fresh average window
            end else begin
                nxt_sum = sum_ff + sext18(i_conv_data);
            end
        end else if (sw_sum_ok && wr_hit(i_addr, ADDR_SUM_L)) begin
            nxt_sum[7:0] = i_wdata;
        end else if (sw_sum_ok && wr_hit(i_addr, ADDR_SUM_H)) begin
            nxt_sum[15:8] = i_wdata;
        end else if (sw_sum_ok && wr_hit(i_addr, ADDR_SUM_U)) begin
            nxt_sum[17:16] = i_wdata[1:0];
        end
    end

    // Running sum register
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sum_ff <= RST_SUM;
        end else begin
            sum_ff <= nxt_sum;
        end
    end

    // Filtered output follows the sum one cycle later
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            filt_ff <= RST_WORD;
        end else begin
            filt_ff <= 16'(SUM_W'($signed(sum_ff) >>> i_shift_amount));
        end
    end

    // Trigger tally: hardware count wins over software write
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            tally_ff <= RST_BYTE;
        end else if (i_conv_done && repeat_mode) begin
            tally_ff <= tally_hit ? RST_BYTE : nxt_tally;
        end else if (wr_hit(i_addr, ADDR_TALLY)) begin
            tally_ff <= i_wdata;
        end
    end

    // Repeat target
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            target_ff <= RST_BYTE;
        end else if (wr_hit(i_addr, ADDR_TARGET)) begin
            target_ff <= i_wdata;
        end
    end

    // Bounds and setpoint
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            lower_ff <= RST_WORD;
            upper_ff <= RST_WORD;
            setpt_ff <= RST_WORD;
        end else if (i_wr) begin
            if (wr_hit(i_addr, ADDR_LOWER_L)) lower_ff[7:0] <= i_wdata;
            if (wr_hit(i_addr, ADDR_LOWER_H)) lower_ff[15:8] <= i_wdata;
            if (wr_hit(i_addr, ADDR_UPPER_L)) upper_ff[7:0] <= i_wdata;
            if (wr_hit(i_addr, ADDR_UPPER_H)) upper_ff[15:8] <= i_wdata;
            if (wr_hit(i_addr, ADDR_SETPT_L)) setpt_ff[7:0] <= i_wdata;
            if (wr_hit(i_addr, ADDR_SETPT_H)) setpt_ff[15:8] <= i_wdata;
        end
    end

    // Extra capacitance select, upper bits dropped
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            charge_ff <= CHARGE_W'(0);
        end else if (wr_hit(i_addr, ADDR_CHARGE)) begin
            charge_ff <= i_wdata[CHARGE_W-1:0];
        end
    end
    assign o_extra_charge_pf = charge_ff;

    // Check strobe one cycle after the deciding conversion
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            check_ff <= 1'b0;
        end else begin
            check_ff <= do_check;
        end
    end

    // Deviation formula and comparisons
    always_comb begin
        case (i_error_formula_select)
            ERROR_FORMULA_SELECT_SAMPLE_PRIOR: dev_error_formula_select = sample_ff - prior_ff;
            ERROR_FORMULA_SELECT_SAMPLE_SETPT: dev_error_formula_select = sample_ff - setpt_ff;
            ERROR_FORMULA_SELECT_PRIOR_SETPT: dev_error_formula_select = prior_ff - setpt_ff;
            ERROR_FORMULA_SELECT_FILT_SETPT: dev_error_formula_select = filt_ff - setpt_ff;
            ERROR_FORMULA_SELECT_FILT_PRIOR: dev_error_formula_select = filt_ff - prior_ff;
            default: dev_error_formula_select = filt_ff;
        endcase
        dev_below = $signed(dev_error_formula_select) < $signed(lower_ff);
        dev_above = $signed(dev_error_formula_select) > $signed(upper_ff);
        case (i_threshold_irq_mode)
            TMD_NEVER: irq_error_formula_select = 1'b0;
            TMD_BELOW: irq_error_formula_select = dev_below;
            TMD_NOT_BELOW: irq_error_formula_select = !dev_below;
            TMD_INSIDE: irq_error_formula_select = !dev_below && !dev_above;
            TMD_OUTSIDE: irq_error_formula_select = dev_below || dev_above;
            TMD_NOT_ABOVE: irq_error_formula_select = !dev_above;
            TMD_ABOVE: irq_error_formula_select = dev_above;
            TMD_ALWAYS: irq_error_formula_select = 1'b1;
            default: irq_error_formula_select = 1'b0;
        endcase
    end

    // Deviation, flags and interrupt pulse captured at check
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            dev_ff <= RST_WORD;
            below_ff <= 1'b0;
            above_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= check_ff && irq_error_formula_select;
            if (check_ff) begin
                dev_ff <= dev_error_formula_select;
                below_ff <= dev_below;
                above_ff <= dev_above;
            end
        end
    end
    assign o_below_lower_flag = below_ff;
    assign o_above_upper_flag = above_ff;
    assign o_threshold_irq = irq_ff;

    // Read mux, data valid the cycle after the strobe
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || !i_rd) begin
            rdata_ff <= RST_BYTE;
        end else begin
            case (i_addr)
                ADDR_LOWER_L[ADDR_W-1:0]: rdata_ff <= lower_ff[7:0];
                ADDR_LOWER_H[ADDR_W-1:0]: rdata_ff <= lower_ff[15:8];
                ADDR_UPPER_L[ADDR_W-1:0]: rdata_ff <= upper_ff[7:0];
                ADDR_UPPER_H[ADDR_W-1:0]: rdata_ff <= upper_ff[15:8];
                ADDR_DEV_L[ADDR_W-1:0]: rdata_ff <= dev_ff[7:0];
                ADDR_DEV_H[ADDR_W-1:0]: rdata_ff <= dev_ff[15:8];
                ADDR_SETPT_L[ADDR_W-1:0]: rdata_ff <= setpt_ff[7:0];
                ADDR_SETPT_H[ADDR_W-1:0]: rdata_ff <= setpt_ff[15:8];
                ADDR_FILT_L[ADDR_W-1:0]: rdata_ff <= filt_ff[7:0];
                ADDR_FILT_H[ADDR_W-1:0]: rdata_ff <= filt_ff[15:8];
                ADDR_SUM_L[ADDR_W-1:0]: rdata_ff <= sum_ff[7:0];
                ADDR_SUM_H[ADDR_W-1:0]: rdata_ff <= sum_ff[15:8];
                ADDR_SUM_U[ADDR_W-1:0]: rdata_ff <= {{6{sum_ff[17]}}, sum_ff[17:16]};
                ADDR_TALLY[ADDR_W-1:0]: rdata_ff <= tally_ff;
                ADDR_TARGET[ADDR_W-1:0]: rdata_ff <= target_ff;
                ADDR_PRIOR_L[ADDR_W-1:0]: rdata_ff <= prior_ff[7:0];
                ADDR_PRIOR_H[ADDR_W-1:0]: rdata_ff <= prior_ff[15:8];
                ADDR_SAMPLE_L[ADDR_W-1:0]: rdata_ff <= sample_ff[7:0];
                ADDR_SAMPLE_H[ADDR_W-1:0]: rdata_ff <= sample_ff[15:8];
                ADDR_CHARGE[ADDR_W-1:0]: rdata_ff <= {3'h0, charge_ff};
                default: rdata_ff <= RST_BYTE;
            endcase
        end
    end
    assign o_rdata = rdata_ff;

    // Checks on the block's own behaviour
    default clocking adccr_cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);

    charge_write_a: assert property (wr_hit(i_addr, ADDR_CHARGE) |=> o_extra_charge_pf == $past(i_wdata[4:0]))
        else $error("capacitance select not taken from write");
    charge_rsvd_a: assert property ((i_rd && i_addr == ADDR_CHARGE[ADDR_W-1:0]) |=> o_rdata[7:5] == 3'h0)
        else $error("capacitance reserved bits not zero");
    check_hit_a: assert property ((i_conv_done && repeat_mode && tally_ff + 8'h01 == target_ff) |=> check_ff)
        else $error("threshold check missed at tally match");
    tally_count_a: assert property ((i_conv_done && repeat_mode && !tally_hit)
        |=> tally_ff == $past(tally_ff) + 8'h01)
        else $error("tally did not advance");
    tally_idle_a: assert property ((!repeat_mode && !i_wr) |=> tally_ff == $past(tally_ff))
        else $error("tally moved outside repeat modes");
    filt_shift_a: assert property (##1 filt_ff == 16'(SUM_W'($signed($past(sum_ff)) >>> $past(i_shift_amount))))
        else $error("filtered output not shifted sum");
    prior_filt_a: assert property ((i_conv_start && i_prior_source_select) |=> prior_ff == $past(filt_ff))
        else $error("earlier outcome not taken from filter");
    prior_sample_a: assert property ((i_conv_start && !i_prior_source_select) |=> prior_ff == $past(sample_ff))
        else $error("earlier outcome not taken from sample");
    sum_lock_a: assert property ((i_conv_active && !i_conv_done) |=> sum_ff == $past(sum_ff))
        else $error("running sum changed during conversion");
    sum_sign_a: assert property ((i_rd && i_addr == ADDR_SUM_U[ADDR_W-1:0]) |=> o_rdata[7:2] == {6{o_rdata[1]}})
        else $error("upper sum byte not sign filled");
    flag_cmp_a: assert property (check_ff |=>
        o_below_lower_flag == ($signed($past(dev_error_formula_select)) < $signed($past(lower_ff)))
        && o_above_upper_flag == ($signed($past(dev_error_formula_select)) > $signed($past(upper_ff))))
        else $error("threshold flags wrong after check");
    irq_never_a: assert property ((check_ff && i_threshold_irq_mode == TMD_NEVER) |=> !o_threshold_irq)
        else $error("interrupt raised in never mode");

    conv_cover_c: cover property (i_conv_done && repeat_mode && tally_hit);
    irq_cover_c: cover property (o_threshold_irq);
    prior_cover_c: cover property (i_conv_start && i_prior_source_select);
endmodule : adccr_regs
`default_nettype wire

// ==== test/adccr_regs_tb.sv ====
// Self-checking bench for the converter computation register block
`timescale 1ns/100ps
`default_nettype none
module adccr_regs_tb;
    import adccr_pkg::*;
    logic i_core_clk, i_sys_rst, i_wr, i_rd, i_conv_start, i_conv_done, i_conv_active, i_prior_source_select;
    logic [15:0] i_addr, i_conv_data;
    logic [7:0] i_wdata, o_rdata;
    logic [2:0] i_comp_mode, i_shift_amount, i_error_formula_select, i_threshold_irq_mode;
    logic [4:0] o_extra_charge_pf;
    logic o_below_lower_flag, o_above_upper_flag, o_threshold_irq, eb, ea;
    integer mismatches, checks, seed, irq_seen, sum, filt, samp, tv, k, m, dev, pr;
    logic [15:0] v;
    logic [7:0] b;
    logic [15:0] dat [3] = '{16'h0050, 16'h0064, 16'h0082};

    adccr_regs uut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_conv_start(i_conv_start), .i_conv_done(i_conv_done),
        .i_conv_data(i_conv_data), .i_conv_active(i_conv_active), .i_comp_mode(i_comp_mode),
        .i_shift_amount(i_shift_amount), .i_prior_source_select(i_prior_source_select),
        .i_error_formula_select(i_error_formula_select), .i_threshold_irq_mode(i_threshold_irq_mode),
        .o_extra_charge_pf(o_extra_charge_pf), .o_below_lower_flag(o_below_lower_flag),
        .o_above_upper_flag(o_above_upper_flag), .o_threshold_irq(o_threshold_irq));

    // Free-running core clock, 40 ns period
    initial begin
        i_core_clk = 1'b0;
        forever #20 i_core_clk = ~i_core_clk;
    end

    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One-cycle bus write
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        i_wdata <= ~d;
    endtask : wr

    // One-cycle bus read, data checked in the following cycle
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        check(32'(o_rdata), 32'(e));
    endtask : rd

    task automatic wr16(input logic [15:0] a, input logic [15:0] d);
        wr(a, d[7:0]);
        wr(a + 16'h0001, d[15:8]);
    endtask : wr16

    task automatic rd16(input logic [15:0] a, input logic [15:0] e);
        rd(a, e[7:0]);
        rd(a + 16'h0001, e[15:8]);
    endtask : rd16

    // Running sum as three byte views, upper byte sign-filled
    task automatic rsum(input integer s);
        rd(ADDR_SUM_L, 8'(s));
        rd(ADDR_SUM_H, 8'(s >>> 8));
        rd(ADDR_SUM_U, 8'(s >>> 16));
    endtask : rsum

    // Conversion done pulse, then count irq pulses over the next cycles
    task automatic conv(input logic [15:0] d);
        @(posedge i_core_clk);
        i_conv_done <= 1'b1;
        i_conv_data <= d;
        @(posedge i_core_clk);
        i_conv_done <= 1'b0;
        i_conv_data <= ~d;
        samp = $signed(d);
        irq_seen = 0;
        repeat (5) begin
            @(posedge i_core_clk);
            #1;
            if (o_threshold_irq === 1'b1) irq_seen = irq_seen + 1;
        end
    endtask : conv

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    // Watchdog against a hung sequence
    initial begin
        repeat (20000) @(posedge i_core_clk);
        mismatches = mismatches + 1;
        print_verdict();
    end

    // Main sequence
    initial begin
        {i_wr, i_rd, i_conv_start, i_conv_done, i_conv_active, i_prior_source_select} = 6'h00;
        {i_addr, i_conv_data, i_wdata} = 40'h0;
        {i_comp_mode, i_shift_amount, i_error_formula_select, i_threshold_irq_mode} = 12'h000;
        {mismatches, checks, sum} = 96'h0;
        seed = 32'h3010;
        i_sys_rst = 1'b1;
        repeat (20) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        foreach (dat[k]) rd16(ADDR_LOWER_L + 16'(2 * k), RST_WORD);
        rd16(ADDR_SETPT_L, RST_WORD);
        rd16(ADDR_SAMPLE_L, RST_WORD);
        rd16(ADDR_PRIOR_L, RST_WORD);
        rd(ADDR_TALLY, RST_BYTE);
        rd(ADDR_TARGET, RST_BYTE);
        rd(16'h1D1F, 8'h00);
        $display("test reset values done");
        for (k = 0; k < 3; k++) begin
            v = 16'($random(seed));
            wr16(ADDR_LOWER_L + 16'(2 * (k % 2)), v);
            rd16(ADDR_LOWER_L + 16'(2 * (k % 2)), v);
            wr16(ADDR_SETPT_L, ~v);
            rd16(ADDR_SETPT_L, ~v);
            wr16(ADDR_SAMPLE_L, v ^ 16'h5A5A);
            rd16(ADDR_SAMPLE_L, v ^ 16'h5A5A);
            wr16(ADDR_DEV_L, v);
            rd16(ADDR_DEV_L, RST_WORD);
            b = 8'($random(seed));
            wr(ADDR_CHARGE, b);
            rd(ADDR_CHARGE, b & 8'h1F);
            check(32'(o_extra_charge_pf), 32'(b[4:0]));
        end
        wr(ADDR_CHARGE, 8'hE0);
        #1;
        check(32'(o_extra_charge_pf), 32'h0);
        tv = 8'($random(seed));
        wr(ADDR_TALLY, 8'(tv));
        rd(ADDR_TALLY, 8'(tv));
        $display("test register access done");
        @(posedge i_core_clk);
        i_conv_active <= 1'b1;
        wr(ADDR_SUM_L, 8'h55);
        wr(ADDR_SUM_U, 8'h01);
        rsum(0);
        @(posedge i_core_clk);
        i_conv_active <= 1'b0;
        wr(ADDR_SUM_L, 8'h01);
        wr(ADDR_SUM_H, 8'h80);
        wr(ADDR_SUM_U, 8'h02);
        rsum(32'hFFFE8001);
        $display("test sum write guard done");
        @(posedge i_core_clk);
        i_comp_mode <= 3'(ADCCR_MODE_ACCUM);
        i_shift_amount <= 3'h2;
        wr(ADDR_SUM_U, 8'h00);
        wr(ADDR_SUM_H, 8'h00);
        wr(ADDR_SUM_L, 8'h00);
        sum = 0;
        for (k = 0; k < 4; k++) begin
            v = 16'($random(seed) % 3000);
            conv(v);
            sum = sum + $signed(v);
            rsum(sum);
            rd16(ADDR_FILT_L, 16'(sum >>> 2));
            rd16(ADDR_SAMPLE_L, v);
        end
        rd(ADDR_TALLY, 8'(tv));
        $display("test accumulate done");
        @(posedge i_core_clk);
        i_comp_mode <= 3'(ADCCR_MODE_LPF);
        i_shift_amount <= 3'h1;
        wr(ADDR_SUM_U, 8'h00);
        wr(ADDR_SUM_H, 8'h00);
        wr(ADDR_SUM_L, 8'h00);
        sum = 0;
        for (k = 0; k < 3; k++) begin
            v = 16'($random(seed) % 1000);
            conv(v);
            sum = sum + $signed(v) - (sum >>> 1);
            filt = sum >>> 1;
            rd16(ADDR_FILT_L, 16'(filt));
        end
        $display("test low-pass done");
        @(posedge i_core_clk);
        i_prior_source_select <= 1'b1;
        for (k = 0; k < 2; k++) begin
            @(posedge i_core_clk);
            i_conv_start <= 1'b1;
            @(posedge i_core_clk);
            i_conv_start <= 1'b0;
            i_prior_source_select <= 1'b0;
            rd16(ADDR_PRIOR_L, (k == 0) ? 16'(filt) : 16'(samp));
        end
        pr = samp;
        $display("test earlier outcome done");
        @(posedge i_core_clk);
        i_comp_mode <= 3'(ADCCR_MODE_BASIC);
        i_error_formula_select <= ERROR_FORMULA_SELECT_SAMPLE_SETPT;
        wr16(ADDR_SETPT_L, 16'h0064);
        wr16(ADDR_LOWER_L, 16'hFFF6);
        wr16(ADDR_UPPER_L, 16'h000A);
        for (m = 0; m < 8; m++) begin
            @(posedge i_core_clk);
            i_threshold_irq_mode <= 3'(m);
            foreach (dat[k]) begin
                conv(dat[k]);
                dev = $signed(dat[k]) - 100;
                eb = dev < -10;
                ea = dev > 10;
                check(32'(o_below_lower_flag), 32'(eb));
                check(32'(o_above_upper_flag), 32'(ea));
                b = {1'b1, ea, !ea, eb | ea, !(eb | ea), !eb, eb, 1'b0};
                check(irq_seen, 32'(b[m]));
                rd16(ADDR_DEV_L, 16'(dev));
            end
        end
        $display("test threshold modes done");
        // Every deviation formula on settled sample, earlier outcome and filter
        for (m = 0; m < 8; m++) begin
            @(posedge i_core_clk);
            i_error_formula_select <= 3'(m);
            conv(dat[2]);
            tv = (m < 2) ? $signed(dat[2]) : (m == 2) ? pr : filt;
            dev = tv - ((m >= 1 && m <= 3) ? 100 : (m == 0 || m == 4) ? pr : 0);
            rd16(ADDR_DEV_L, 16'(dev));
        end
        $display("test deviation formulas done");
        @(posedge i_core_clk);
        i_comp_mode <= 3'(ADCCR_MODE_AVG);
        wr(ADDR_TARGET, 8'h03);
        wr(ADDR_TALLY, 8'h00);
        for (k = 1; k <= 3; k++) begin
            conv(16'($random(seed) % 500));
            check(irq_seen, (k == 3) ? 32'h1 : 32'h0);
            rd(ADDR_TALLY, (k == 3) ? 8'h00 : 8'(k));
        end
        $display("test repeat count done");
        print_verdict();
    end
endmodule : adccr_regs_tb
`default_nettype wire
